// file: sfcr_pkg.sv
// Constants, opcodes and types of the serial flash command front end
package sfcr_pkg;

    // Widths
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W  = 9;

    // Byte framing
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] BIT_FIRST   = 3'h0;
    localparam logic [1:0] ADDR_LAST   = 2'h2;
    localparam logic [1:0] DUMMY_NONE  = 2'h0;
    localparam logic [1:0] DUMMY_FAST  = 2'h1;
    localparam logic [1:0] DUMMY_SEC   = 2'h2;
    localparam logic [CNT_W-1:0] PAGE_BYTES = 9'h100;

    // Reset values and step sizes
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_STEP  = 9'h001;

    // Opcodes
    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_ERASE_4K  = 8'h20;
    localparam logic [7:0] OP_ERASE_32A = 8'h52;
    localparam logic [7:0] OP_ERASE_32B = 8'hD8;
    localparam logic [7:0] OP_CHIP_A    = 8'h60;
    localparam logic [7:0] OP_CHIP_B    = 8'hC7;
    localparam logic [7:0] OP_CHIP_OLD  = 8'h62;
    localparam logic [7:0] OP_PROGRAM   = 8'h02;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_SEC_PROG  = 8'h9B;
    localparam logic [7:0] OP_SEC_READ  = 8'h77;
    localparam logic [7:0] OP_STAT_RD   = 8'h05;
    localparam logic [7:0] OP_STAT_WR   = 8'h01;
    localparam logic [7:0] OP_ID_READ   = 8'h9F;
    localparam logic [7:0] OP_ID_OLD    = 8'h15;
    localparam logic [7:0] OP_SLEEP     = 8'hB9;
    localparam logic [7:0] OP_WAKE      = 8'hAB;

    // Decoded commands
    typedef enum logic [4:0] {
        CMD_NONE, CMD_READ_FAST, CMD_READ_SLOW, CMD_ERASE_4K, CMD_ERASE_32K,
        CMD_CHIP_ERASE, CMD_PROGRAM, CMD_WR_EN, CMD_WR_DIS, CMD_SEC_PROG,
        CMD_SEC_READ, CMD_STAT_RD, CMD_STAT_WR, CMD_ID_READ, CMD_ID_OLD,
        CMD_SLEEP, CMD_WAKE
    } sfcr_cmd_t;

    // Source of outgoing read bytes
    typedef enum logic [1:0] {
        SRC_ARRAY, SRC_SECURITY, SRC_STATUS, SRC_ID
    } sfcr_src_t;

endpackage

// file: sfcr_front.sv
// Serial flash command front end: opcode decode, header capture and read byte stream
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Sample input on serial clock rise, update output on fall; modes 0 and 3.
// - All bytes travel most significant bit first, both directions.
// - Chip select release ends the current operation.
// - Unknown opcode: nothing starts, input ignored until select is re-asserted.
// - Release before opcode and address complete: nothing performed, back to idle.
// - Addressed commands carry three address bytes, highest first.
// - Upper address byte ignored; only sixteen low bits kept.
// - Fast read 0Bh has one dummy byte; 03h has none.
// - Block erase 20h is 4K, 52h and D8h are 32K, all addressed.
// - Program 02h takes an address then up to a page of data. Here every data byte is passed on; only the count stops at 256.
// - Chip erase 60h, C7h, 62h take no further bytes.
// - 9Bh programs security data; 77h reads it after two dummy bytes.
// - 9Fh reads identification bytes; legacy 15h reads two of them. Here 15h streams ID bytes until release, like 9Fh.
// - B9h enters deep power-down, ABh resumes; no further bytes.
// - Read loads the start address into a counter that advances per byte.
// - After header, data goes out on following clocks, MSB first.
// - Counter wraps from top location to zero with no extra clocks.
// - Release ends a read mid-byte and floats the output.
// - Output floats and input is ignored while deselected.
module sfcr_front
    import sfcr_pkg::*;
(
    // Clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     reset_i,
    // Serial link pins
    input  wire logic                     sck_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     si_i,
    output logic                          so_o,
    output logic                          so_oe_o,
    // Read byte source
    output logic                          rd_req_o,
    output logic [sfcr_pkg::ADDR_W-1:0]   rd_addr_o,
    output sfcr_pkg::sfcr_src_t           rd_src_o,
    input  wire logic [sfcr_pkg::BYTE_W-1:0] rd_data_i,
    // Incoming data bytes
    output logic                          wr_valid_o,
    output logic [sfcr_pkg::BYTE_W-1:0]   wr_byte_o,
    // Completed command report
    output logic                          done_o,
    output sfcr_pkg::sfcr_cmd_t           done_cmd_o,
    output logic [sfcr_pkg::ADDR_W-1:0]   done_addr_o,
    output logic [sfcr_pkg::CNT_W-1:0]    done_count_o,
    output logic                          done_aligned_o
);
    import sfcr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY,
        ST_DATA_OUT, ST_DATA_IN, ST_TAIL, ST_IGNORE
    } sfcr_state_t;

    typedef struct packed {
        logic                sck_m;
        logic                sck_s;
        logic                sck_d;
        logic                cs_m;
        logic                cs_s;
        logic                si_m;
        logic                si_s;
        sfcr_state_t         st;
        sfcr_cmd_t           cmd;
        logic [2:0]          bit_cnt;
        logic [1:0]          byte_cnt;
        logic [BYTE_W-1:0]   sh_in;
        logic [ADDR_W-1:0]   addr;
        logic [BYTE_W-1:0]   sh_out;
        logic [BYTE_W-1:0]   fetch;
        logic                so;
        logic                so_oe;
        logic                rd_req;
        logic [ADDR_W-1:0]   rd_addr;
        sfcr_src_t           rd_src;
        logic                wr_valid;
        logic [BYTE_W-1:0]   wr_byte;
        logic [CNT_W-1:0]    data_cnt;
        logic                done;
        sfcr_cmd_t           done_cmd;
        logic [ADDR_W-1:0]   done_addr;
        logic [CNT_W-1:0]    done_cnt;
        logic                done_aligned;
    } sfcr_regs_t;

    localparam sfcr_regs_t REGS_RST = '{
        sck_m: 1'b0, sck_s: 1'b0, sck_d: 1'b0,
        cs_m: 1'b1, cs_s: 1'b1, si_m: 1'b0, si_s: 1'b0,
        st: ST_IDLE, cmd: CMD_NONE,
        bit_cnt: BIT_FIRST, byte_cnt: DUMMY_NONE,
        sh_in: BYTE_RST, addr: ADDR_RST, sh_out: BYTE_RST,
        fetch: BYTE_RST, so: 1'b0, so_oe: 1'b0,
        rd_req: 1'b0, rd_addr: ADDR_RST, rd_src: SRC_ARRAY,
        wr_valid: 1'b0, wr_byte: BYTE_RST, data_cnt: '0,
        done: 1'b0, done_cmd: CMD_NONE, done_addr: ADDR_RST,
        done_cnt: '0, done_aligned: 1'b0
    };

    sfcr_regs_t r;
    sfcr_regs_t n;

    // Opcode to command decode; anything else is unsupported
    function automatic sfcr_cmd_t decode(input logic [7:0] op);
        sfcr_cmd_t c;
        unique case (op)
            OP_READ_FAST: c = CMD_READ_FAST;
            OP_READ_SLOW: c = CMD_READ_SLOW;
            OP_ERASE_4K:  c = CMD_ERASE_4K;
            OP_ERASE_32A,
            OP_ERASE_32B: c = CMD_ERASE_32K;
            OP_CHIP_A,
            OP_CHIP_B,
            OP_CHIP_OLD:  c = CMD_CHIP_ERASE;
            OP_PROGRAM:   c = CMD_PROGRAM;
            OP_WR_EN:     c = CMD_WR_EN;
            OP_WR_DIS:    c = CMD_WR_DIS;
            OP_SEC_PROG:  c = CMD_SEC_PROG;
            OP_SEC_READ:  c = CMD_SEC_READ;
            OP_STAT_RD:   c = CMD_STAT_RD;
            OP_STAT_WR:   c = CMD_STAT_WR;
            OP_ID_READ:   c = CMD_ID_READ;
            OP_ID_OLD:    c = CMD_ID_OLD;
            OP_SLEEP:     c = CMD_SLEEP;
            OP_WAKE:      c = CMD_WAKE;
            default:      c = CMD_NONE;
        endcase
        return c;
    endfunction

    // Commands followed by three address bytes
    function automatic logic has_addr(input sfcr_cmd_t c);
        return c inside {CMD_READ_FAST, CMD_READ_SLOW, CMD_ERASE_4K,
                         CMD_ERASE_32K, CMD_PROGRAM, CMD_SEC_PROG,
                         CMD_SEC_READ};
    endfunction

    // Dummy bytes between address and read data
    function automatic logic [1:0] dummies(input sfcr_cmd_t c);
        logic [1:0] d;
        unique case (c)
            CMD_READ_FAST: d = DUMMY_FAST;
            CMD_SEC_READ:  d = DUMMY_SEC;
            default:       d = DUMMY_NONE;
        endcase
        return d;
    endfunction

    // Commands that stream bytes out
    function automatic logic is_read(input sfcr_cmd_t c);
        return c inside {CMD_READ_FAST, CMD_READ_SLOW, CMD_SEC_READ,
                         CMD_STAT_RD, CMD_ID_READ, CMD_ID_OLD};
    endfunction

    // Commands that take data bytes in
    function automatic logic is_write(input sfcr_cmd_t c);
        return c inside {CMD_PROGRAM, CMD_SEC_PROG, CMD_STAT_WR};
    endfunction

    // Where outgoing bytes come from
    function automatic sfcr_src_t source(input sfcr_cmd_t c);
        sfcr_src_t s;
        unique case (c)
            CMD_SEC_READ: s = SRC_SECURITY;
            CMD_STAT_RD:  s = SRC_STATUS;
            CMD_ID_READ,
            CMD_ID_OLD:   s = SRC_ID;
            default:      s = SRC_ARRAY;
        endcase
        return s;
    endfunction

    // Next-state logic
    always_comb
    begin
        logic             rise;
        logic             fall;
        logic             last_bit;
        logic [7:0]       byte_in;
        logic [ADDR_W-1:0] addr_in;
        logic             start_out;
        rise      = 1'b0;
        fall      = 1'b0;
        last_bit  = 1'b0;
        byte_in   = BYTE_RST;
        addr_in   = ADDR_RST;
        start_out = 1'b0;
        n = r;

        // Two-stage synchronisers for all pins
        n.sck_m = sck_i;
        n.sck_s = r.sck_m;
        n.sck_d = r.sck_s;
        n.cs_m  = cs_n_i;
        n.cs_s  = r.cs_m;
        n.si_m  = si_i;
        n.si_s  = r.si_m;

        rise     = r.sck_s & ~r.sck_d;
        fall     = ~r.sck_s & r.sck_d;
        last_bit = rise && (r.bit_cnt == BIT_LAST);
        byte_in  = {r.sh_in[6:0], r.si_s};
        addr_in  = {r.addr[ADDR_W-2:0], r.si_s};

        n.rd_req   = 1'b0;
        n.wr_valid = 1'b0;
        n.done     = 1'b0;

        // Capture the byte returned for the last request
        if (r.rd_req)
        begin
            n.fetch = rd_data_i;
        end

        if (r.cs_s)
        begin
            // Deselected: report complete commands, float output
            if (r.st inside {ST_DATA_OUT, ST_DATA_IN, ST_TAIL})
            begin
                n.done         = 1'b1;
                n.done_cmd     = r.cmd;
                n.done_addr    = r.addr;
                n.done_cnt     = r.data_cnt;
                n.done_aligned = (r.bit_cnt == BIT_FIRST);
            end
            n.st       = ST_IDLE;
            n.so_oe    = 1'b0;
            n.so       = 1'b0;
            n.bit_cnt  = BIT_FIRST;
            n.byte_cnt = DUMMY_NONE;
            n.data_cnt = '0;
        end
        else
        begin
            // Shift in on rising edges while the header or data is taken
            if (rise && (r.st inside {ST_OPCODE, ST_ADDR, ST_DUMMY,
                                      ST_DATA_IN, ST_TAIL}))
            begin
                n.sh_in   = byte_in;
                n.bit_cnt = r.bit_cnt + 3'h1;
            end
            unique case (r.st)
                ST_IDLE:
                begin
                    n.st  = ST_OPCODE;
                    n.cmd = CMD_NONE;
                end
                ST_OPCODE:
                begin
                    if (last_bit)
                    begin
                        n.cmd = decode(byte_in);
                        if (decode(byte_in) == CMD_NONE)
                            n.st = ST_IGNORE;
                        else if (has_addr(decode(byte_in)))
                            n.st = ST_ADDR;
                        else if (is_write(decode(byte_in)))
                            n.st = ST_DATA_IN;
                        else if (is_read(decode(byte_in)))
                            start_out = 1'b1;
                        else
                            n.st = ST_TAIL;
                    end
                end
                ST_ADDR:
                begin
                    if (rise)
                    begin
                        n.addr = addr_in;
                    end
                    if (last_bit)
                    begin
                        n.byte_cnt = r.byte_cnt + 2'h1;
                        if (r.byte_cnt == ADDR_LAST)
                        begin
                            n.byte_cnt = DUMMY_NONE;
                            if (dummies(r.cmd) != DUMMY_NONE)
                                n.st = ST_DUMMY;
                            else if (is_read(r.cmd))
                                start_out = 1'b1;
                            else if (is_write(r.cmd))
                                n.st = ST_DATA_IN;
                            else
                                n.st = ST_TAIL;
                        end
                    end
                end
                ST_DUMMY:
                begin
                    if (last_bit)
                    begin
                        n.byte_cnt = r.byte_cnt + 2'h1;
                        if (r.byte_cnt + 2'h1 == dummies(r.cmd))
                            start_out = 1'b1;
                    end
                end
                ST_DATA_IN:
                begin
                    if (last_bit)
                    begin
                        n.wr_byte  = byte_in;
                        n.wr_valid = 1'b1;
                        if (r.data_cnt != PAGE_BYTES)
                            n.data_cnt = r.data_cnt + CNT_STEP;
                    end
                end
                ST_DATA_OUT:
                begin
                    if (fall)
                    begin
                        n.so_oe   = 1'b1;
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == BIT_FIRST)
                        begin
                            // New byte: MSB out, prefetch the next one
                            n.so      = r.fetch[7];
                            n.sh_out  = {r.fetch[6:0], 1'b0};
                            n.rd_req  = 1'b1;
                            n.rd_addr = r.rd_addr + ADDR_STEP;
                            if (r.data_cnt != PAGE_BYTES)
                                n.data_cnt = r.data_cnt + CNT_STEP;
                        end
                        else
                        begin
                            n.so     = r.sh_out[7];
                            n.sh_out = {r.sh_out[6:0], 1'b0};
                        end
                    end
                end
                ST_TAIL:
                begin
                    n.st = ST_TAIL;
                end
                ST_IGNORE:
                begin
                    n.st = ST_IGNORE;
                end
            endcase

            // Load the counter and fetch the first outgoing byte
            if (start_out)
            begin
                n.st       = ST_DATA_OUT;
                n.byte_cnt = DUMMY_NONE;
                n.bit_cnt  = BIT_FIRST;
                n.rd_req   = 1'b1;
                n.rd_src   = source(n.cmd);
                n.rd_addr  = (r.st == ST_ADDR) ? addr_in : r.addr;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            r <= REGS_RST;
        else
            r <= n;
    end

    // Outputs straight from the state register
    assign so_o           = r.so;
    assign so_oe_o        = r.so_oe;
    assign rd_req_o       = r.rd_req;
    assign rd_addr_o      = r.rd_addr;
    assign rd_src_o       = r.rd_src;
    assign wr_valid_o     = r.wr_valid;
    assign wr_byte_o      = r.wr_byte;
    assign done_o         = r.done;
    assign done_cmd_o     = r.done_cmd;
    assign done_addr_o    = r.done_addr;
    assign done_count_o   = r.done_cnt;
    assign done_aligned_o = r.done_aligned;

endmodule

`default_nettype wire

// file: sfcr_front_assertions.sv
// Port checker of the serial flash command front end
`timescale 1ns/1ns
`default_nettype none
module sfcr_front_checker
    import sfcr_pkg::*;
(
    // Clock and reset
    input wire logic                        mclk_i,
    input wire logic                        reset_i,
    // Serial link pins
    input wire logic                        sck_i,
    input wire logic                        cs_n_i,
    input wire logic                        so_o,
    input wire logic                        so_oe_o,
    // Reports
    input wire logic                        rd_req_o,
    input wire logic [sfcr_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic                        done_o,
    input wire logic [sfcr_pkg::CNT_W-1:0]  done_count_o
);
    // Last read address of the open frame
    logic [ADDR_W-1:0] last_addr;
    logic              last_ok;
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            last_addr <= ADDR_RST;
            last_ok   <= 1'b0;
        end
        else if (cs_n_i)
            last_ok <= 1'b0;
        else if (rd_req_o)
        begin
            last_addr <= rd_addr_o;
            last_ok   <= 1'b1;
        end
    end
    // Single clock domain
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence desel_s;
        cs_n_i [*5];
    endsequence
    sequence req_gap_s;
        !rd_req_o [*3];
    endsequence
    so_idle_zero_a: assert property (!so_oe_o |-> !so_o) else $error("so high while disabled");
    release_float_a: assert property (desel_s |-> !so_oe_o) else $error("so enabled after release");
    so_on_fall_a: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sck_i, 3))
        else $error("so changed off a falling edge");
    done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    done_release_a: assert property (done_o |-> $past(cs_n_i, 2)) else $error("done without release");
    req_spacing_a: assert property (rd_req_o |=> req_gap_s) else $error("read requests too close");
    addr_step_a: assert property (rd_req_o && last_ok |-> rd_addr_o == last_addr + ADDR_STEP)
        else $error("read address did not advance by one");
    count_cap_a: assert property (done_o |-> done_count_o <= PAGE_BYTES) else $error("count above page");
endmodule
bind sfcr_front sfcr_front_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .done_o(done_o),
    .done_count_o(done_count_o));
`default_nettype wire

// file: sfcr_host.sv
// Host serial master model for the flash command front end
`timescale 1ns/1ns
`default_nettype none
module sfcr_host
(
    // Serial link pins
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    // Bits to send and bits seen
    logic tx [0:1023];
    logic rx [0:1023];
    // Idle levels
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // One framed transfer, 32 ns serial clock, below the low rate limit
    task automatic frame(input bit mode3, input int n);
        int i;
        sck_o = mode3;
        #17;
        cs_n_o = 1'b0;
        #16;
        sck_o = 1'b0;
        for (i = 0; i < n; i++)
        begin
            si_o = tx[i];
            #16;
            sck_o = 1'b1;
            #15;
            rx[i] = so_oe_i ? so_i : 1'bz;
            #1;
            if (i < n - 1 || !mode3)
                sck_o = 1'b0;
        end
        #15;
        rx[n] = so_oe_i ? so_i : 1'bz;
        #1;
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #16;
    endtask
endmodule
`default_nettype wire

// file: sfcr_front_tb.sv
// Self-checking testbench of the flash command front end
`timescale 1ns/1ns
`default_nettype none
module sfcr_front_tb;
    import sfcr_pkg::*;
    logic              mclk_i, reset_i, sck_i, cs_n_i, si_i, so_o, so_oe_o, rd_req_o, wr_valid_o, done_o;
    logic              done_aligned_o;
    logic [ADDR_W-1:0] rd_addr_o, done_addr_o;
    logic [BYTE_W-1:0] rd_data_i, wr_byte_o;
    logic [CNT_W-1:0]  done_count_o;
    sfcr_src_t         rd_src_o;
    sfcr_cmd_t         done_cmd_o;
    int                fail_count, compares, nb, dones;
    logic [7:0]        wq [$];
    localparam logic [12:0] T [13] = '{{CMD_ERASE_4K, OP_ERASE_4K}, {CMD_ERASE_32K, OP_ERASE_32A},
        {CMD_ERASE_32K, OP_ERASE_32B}, {CMD_CHIP_ERASE, OP_CHIP_A}, {CMD_CHIP_ERASE, OP_CHIP_B},
        {CMD_CHIP_ERASE, OP_CHIP_OLD}, {CMD_WR_EN, OP_WR_EN}, {CMD_WR_DIS, OP_WR_DIS}, {CMD_SLEEP, OP_SLEEP},
        {CMD_WAKE, OP_WAKE}, {CMD_STAT_RD, OP_STAT_RD}, {CMD_ID_READ, OP_ID_READ}, {CMD_ID_OLD, OP_ID_OLD}};
    sfcr_host u_host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_i(so_oe_o));
    sfcr_front u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
        .so_o(so_o), .so_oe_o(so_oe_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_src_o(rd_src_o),
        .rd_data_i(rd_data_i), .wr_valid_o(wr_valid_o), .wr_byte_o(wr_byte_o), .done_o(done_o),
        .done_cmd_o(done_cmd_o), .done_addr_o(done_addr_o), .done_count_o(done_count_o),
        .done_aligned_o(done_aligned_o));
    // Clock
    initial mclk_i = 1'b0;
    always #2 mclk_i = ~mclk_i;
    // Byte held by the read source at each place
    function automatic logic [7:0] src_byte(input logic [15:0] a, input sfcr_src_t s);
        return a[7:0] ^ {a[15:10], 2'(s)} ^ 8'h5A;
    endfunction
    always_comb rd_data_i = src_byte(rd_addr_o, rd_src_o);
    // Release reports and received bytes
    always @(posedge mclk_i)
    begin
        if (done_o === 1'b1)
            dones++;
        if (wr_valid_o === 1'b1)
            wq.push_back(wr_byte_o);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic add(input logic [7:0] b);
        for (int k = 7; k >= 0; k--)
            u_host.tx[nb++] = b[k];
    endtask
    task automatic send(input bit mode3, input int extra, input int n_done);
        int d0;
        d0 = dones;
        repeat (extra) u_host.tx[nb++] = 1'($urandom);
        u_host.frame(mode3, nb);
        repeat (8) @(posedge mclk_i);
        check(dones - d0, n_done);
    endtask
    task automatic hdr(input logic [7:0] op, input logic [15:0] a);
        nb = 0;
        add(op);
        add(8'($urandom));
        add(a[15:8]);
        add(a[7:0]);
    endtask
    task automatic rd(input logic [7:0] op, input int ndum, input sfcr_src_t src, input logic [15:0] a,
                      input int nbytes, input int extra, input sfcr_cmd_t cmd);
        int h;
        logic [7:0] got;
        hdr(op, a);
        repeat (ndum) add(8'($urandom));
        h = nb;
        send(1'b0, nbytes * 8 + extra, 1);
        for (int j = 0; j < nbytes; j++)
        begin
            for (int k = 0; k < 8; k++)
                got[7 - k] = u_host.rx[h + 8 * j + k];
            check(got, src_byte(a + 16'(j), src));
        end
        check(rd_src_o, src);
        check(done_cmd_o, cmd);
        check(done_addr_o, a);
    endtask
    task automatic wr(input logic [7:0] op, input bit addr, input int n, input sfcr_cmd_t cmd);
        logic [7:0] d [$];
        logic [15:0] a;
        a = 16'($urandom);
        wq.delete();
        hdr(op, a);
        if (!addr)
            nb = 8;
        for (int j = 0; j < n; j++)
        begin
            d.push_back(8'($urandom));
            add(d[j]);
        end
        send(1'b1, 0, 1);
        check(wq.size(), n);
        foreach (d[j]) check(wq[j], d[j]);
        check(done_count_o, n);
        check(done_aligned_o, 1'b1);
        check(done_cmd_o, cmd);
        if (addr)
            check(done_addr_o, a);
    endtask
    // Main sequence
    initial
    begin
        logic [15:0] a;
        void'($urandom(62));
        fail_count = 0;
        compares = 0;
        dones = 0;
        reset_i = 1'b1;
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check(done_cmd_o, CMD_NONE);
        rd(OP_READ_FAST, 1, SRC_ARRAY, 16'($urandom), 4, 0, CMD_READ_FAST);
        rd(OP_READ_SLOW, 0, SRC_ARRAY, 16'hFFFE, 4, 0, CMD_READ_SLOW);
        rd(OP_READ_SLOW, 0, SRC_ARRAY, 16'($urandom), 1, 3, CMD_READ_SLOW);
        check(so_oe_o, 1'b0);
        rd(OP_SEC_READ, 2, SRC_SECURITY, 16'($urandom), 2, 0, CMD_SEC_READ);
        for (int i = 0; i < 13; i++)
        begin
            a = 16'($urandom);
            if (i < 3)
                hdr(T[i][7:0], a);
            else
            begin
                nb = 0;
                add(T[i][7:0]);
            end
            send(1'($urandom), 8, 1);
            check(done_cmd_o, T[i][12:8]);
            if (i < 3)
                check(done_addr_o, a);
        end
        wr(OP_PROGRAM, 1'b1, int'($urandom_range(4, 1)), CMD_PROGRAM);
        wr(OP_SEC_PROG, 1'b1, 2, CMD_SEC_PROG);
        wr(OP_STAT_WR, 1'b0, 1, CMD_STAT_WR);
        wq.delete();
        nb = 0;
        add(8'hFF);
        add(OP_WR_EN);
        send(1'b0, 16, 0);
        check(wq.size(), 0);
        hdr(OP_PROGRAM, 16'h1234);
        nb = 24;
        send(1'b0, 3, 0);
        wrap_up();
    end
    // Hang guard
    initial
    begin
        #300000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
